/* File: verilog/spg_top.v */
/*
 * Stepper pulse train generator with an APB register slave. Emits square
 * wave step pulses on one dedicated fast output: normal jobs with linear
 * ramp up, constant run and ramp down, plus jog step and jog manual modes.
 * Assumes one 20 MHz clock, APB inputs synchronous to it, and an external
 * power stage reading the fast output.
 */
// Overview of operation
// - pulse count on the fast output equals the programmed count
// - each step is high for its half period and low as long, or longer for halves under 21 cycles while the divider runs
// - the generator drives its pin in ST_RUN; in every other state the software pin level shows
// - normal job runs acceleration, constant run, then deceleration
// - acceleration raises frequency per step from start to operating
// - deceleration lowers frequency per step from operating to start
// - accel steps equal (operating minus start) times 1000 over increment
// - brake steps equal (operating minus start) times 1000 over decrement
// - run steps equal total minus accel and brake steps
// - an uninterrupted normal job emits exactly the total count
// - start and jog are honoured only while enable is set
// - raising jog instead runs the generator in jog mode
// - jog step mode emits the jog step count
// - jog manual mode ramps up to and holds the jog frequency
// - enable falling resets at once, no braking ramp
// - start edge while a job is active is ignored
// - brake edge in a normal job aborts into braking; active clears when braking ends
// - jog held at most half a second selects step mode, else manual
`timescale 1ns/1ps
`default_nettype none
`include "spg_defs.vh"

module spg_top #(
    parameter [23:0] JOG_LONG_CYC = `SPG_JOG_LONG_CYC
) (
    input  wire        clk_sys_i,
    input  wire        arst_n_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    output reg         fast_output_one_o,
    output reg         job_active_o
);
    localparam [31:0] MHZ      = `SPG_MHZ_PER_HZ;
    localparam [39:0] HALF_NUM = (`SPG_CLK_HZ * `SPG_MHZ_PER_HZ) / 2;
    localparam [2:0]  ST_IDLE  = 3'h0;
    localparam [2:0]  ST_ACC   = 3'h1;
    localparam [2:0]  ST_BRK   = 3'h2;
    localparam [2:0]  ST_HALF  = 3'h3;
    localparam [2:0]  ST_RUN   = 3'h4;
    localparam [1:0]  M_NORMAL = 2'h0;
    localparam [1:0]  M_JSTEP  = 2'h1;
    localparam [1:0]  M_JMAN   = 2'h2;

    function [3:0] spg_index;
        input [7:0] a;
        begin
            if (a[1:0] == 2'b00 && a[7:6] == 2'b00 &&
                a[5:2] <= `SPG_IDX_LAST)
                spg_index = a[5:2];
            else
                spg_index = `SPG_IDX_NONE;
        end
    endfunction

    reg [`SPG_CTRL_W-1:0] ctrl;
    reg [31:0]            total_step_count;
    reg [`SPG_FREQ_W-1:0] start_frequency, operating_frequency;
    reg [31:0]            accel_step_increment, brake_step_decrement;
    reg [31:0]            jog_step_count;
    reg [`SPG_FREQ_W-1:0] jog_frequency;
    reg [2:0]  state;
    reg [1:0]  mode;
    reg [31:0] rem, accel_n, brake_n, current_frequency;
    reg [31:0] next_mhz, half_len, half_cnt, dv_r, dv_d;
    reg [23:0] jog_cnt;
    reg [39:0] dv_q;
    reg [5:0]  dv_cnt;
    reg        counted, brk_mode, out_q, need_calc, last_step;
    reg        jog_timing, dv_busy, en_d, start_d, brk_d, jog_d;

    wire        en   = ctrl[`SPG_CTRL_ENABLE];
    wire        strt = ctrl[`SPG_CTRL_START];
    wire        brk  = ctrl[`SPG_CTRL_BRAKE];
    wire        jog  = ctrl[`SPG_CTRL_JOG];
    wire [3:0]  idx  = spg_index(paddr_i);
    wire        setup = psel_i & ~penable_i;
    wire        wr_acc = psel_i & penable_i & pwrite_i & pready_o;
    wire [31:0] fs_m = {12'h000, start_frequency} * MHZ;
    wire [31:0] fo_m = {12'h000, operating_frequency} * MHZ;
    wire [31:0] pf_m = {12'h000, jog_frequency} * MHZ;
    wire [31:0] diff_m = (fo_m > fs_m) ? fo_m - fs_m : 32'h00000000;
    wire [33:0] dv_trial = {1'b0, dv_r, dv_q[39]} - {2'b00, dv_d};
    wire [31:0] dv_sat = (|dv_q[39:32]) ? 32'hffffffff : dv_q[31:0];
    wire [31:0] half_q = (dv_sat == 32'h00000000) ? 32'h00000001 : dv_sat;
    reg  [31:0] top_m, nf, rd_val;

    // next step frequency, decided once per step from the remaining count
    always @* begin
        case (mode)
            M_JMAN:  top_m = pf_m;
            M_JSTEP: top_m = fs_m;
            default: top_m = fo_m;
        endcase
        if (brk_mode || (mode == M_NORMAL && rem <= brake_n)) begin
            if (current_frequency > fs_m &&
                current_frequency - fs_m > brake_step_decrement)
                nf = current_frequency - brake_step_decrement;
            else
                nf = fs_m;
        end else if (current_frequency < top_m &&
                     top_m - current_frequency > accel_step_increment) begin
            nf = current_frequency + accel_step_increment;
        end else begin
            nf = top_m;
        end
    end

    always @* begin
        case (idx)
            `SPG_IDX_CTRL:      rd_val = {27'h0000000, ctrl};
            `SPG_IDX_TOTAL:     rd_val = total_step_count;
            `SPG_IDX_FSTART:    rd_val = {12'h000, start_frequency};
            `SPG_IDX_FOPER:     rd_val = {12'h000, operating_frequency};
            `SPG_IDX_ACCEL_INC: rd_val = accel_step_increment;
            `SPG_IDX_BRAKE_DEC: rd_val = brake_step_decrement;
            `SPG_IDX_JOG_STEPS: rd_val = jog_step_count;
            `SPG_IDX_JOG_FREQ:  rd_val = {12'h000, jog_frequency};
            `SPG_IDX_STATUS:    rd_val = {23'h000000, mode, brk_mode,
                                          jog_timing, out_q, state,
                                          job_active_o};
            `SPG_IDX_CUR_FREQ:  rd_val = current_frequency;
            `SPG_IDX_ACCEL_N:   rd_val = accel_n;
            `SPG_IDX_BRAKE_N:   rd_val = brake_n;
            default:            rd_val = 32'h00000000;
        endcase
    end

    // apb slave: one wait-free access cycle, data latched at setup
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_o             <= 32'h00000000;
            pready_o             <= 1'b0;
            pslverr_o            <= 1'b0;
            ctrl                 <= `SPG_CTRL_RST;
            total_step_count     <= `SPG_CFG_RST;
            start_frequency      <= `SPG_FREQ_RST;
            operating_frequency  <= `SPG_FREQ_RST;
            accel_step_increment <= `SPG_CFG_RST;
            brake_step_decrement <= `SPG_CFG_RST;
            jog_step_count       <= `SPG_CFG_RST;
            jog_frequency        <= `SPG_FREQ_RST;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup & (idx == `SPG_IDX_NONE);
            if (setup)
                prdata_o <= rd_val;
            if (wr_acc) begin
                case (idx)
                    `SPG_IDX_CTRL:
                        ctrl <= pwdata_i[`SPG_CTRL_W-1:0];
                    `SPG_IDX_TOTAL:
                        total_step_count <= pwdata_i;
                    `SPG_IDX_FSTART:
                        start_frequency <= pwdata_i[`SPG_FREQ_W-1:0];
                    `SPG_IDX_FOPER:
                        operating_frequency <= pwdata_i[`SPG_FREQ_W-1:0];
                    `SPG_IDX_ACCEL_INC:
                        accel_step_increment <= pwdata_i;
                    `SPG_IDX_BRAKE_DEC:
                        brake_step_decrement <= pwdata_i;
                    `SPG_IDX_JOG_STEPS:
                        jog_step_count <= pwdata_i;
                    `SPG_IDX_JOG_FREQ:
                        jog_frequency <= pwdata_i[`SPG_FREQ_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    task spg_launch;
        input [39:0] num;
        input [31:0] den;
        begin
            dv_q    <= num;
            dv_r    <= 32'h00000000;
            dv_d    <= den;
            dv_cnt  <= 6'd40;
            dv_busy <= 1'b1;
        end
    endtask
    task spg_step_start;
        input [31:0] freq;
        begin
            current_frequency <= freq;
            half_len          <= half_q;
            half_cnt          <= half_q;
            out_q             <= 1'b1;
            need_calc         <= 1'b1;
            if (counted)
                rem <= rem - 32'h00000001;
        end
    endtask
    // job engine with a shared 40-cycle restoring divider
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_IDLE; mode <= M_NORMAL; counted <= 1'b0;
            brk_mode <= 1'b0; rem <= 32'h00000000;
            accel_n <= 32'h00000000; brake_n <= 32'h00000000;
            current_frequency <= 32'h00000000; next_mhz <= 32'h00000000;
            half_len <= 32'h00000001; half_cnt <= 32'h00000001;
            out_q <= 1'b0; need_calc <= 1'b0; last_step <= 1'b0;
            jog_timing <= 1'b0; jog_cnt <= 24'h000000;
            en_d <= 1'b0; start_d <= 1'b0; brk_d <= 1'b0; jog_d <= 1'b0;
            dv_q <= 40'h0000000000; dv_r <= 32'h00000000;
            dv_d <= 32'h00000000; dv_cnt <= 6'h00; dv_busy <= 1'b0;
            job_active_o <= 1'b0; fast_output_one_o <= 1'b0;
        end else begin
            en_d    <= en;
            start_d <= strt;
            brk_d   <= brk;
            jog_d   <= jog;
            job_active_o <= (state != ST_IDLE);
            // software pin level reaches the pin in every state except ST_RUN
            fast_output_one_o <= (state == ST_RUN) ? out_q
                                 : ctrl[`SPG_CTRL_PIN];
            if (dv_busy) begin
                dv_q <= {dv_q[38:0], ~dv_trial[33]};
                dv_r <= dv_trial[33] ? {dv_r[30:0], dv_q[39]}
                                     : dv_trial[31:0];
                dv_cnt <= dv_cnt - 6'd1;
                if (dv_cnt == 6'd1)
                    dv_busy <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (en && jog && !jog_d && !jog_timing) begin
                        jog_timing <= 1'b1;
                        jog_cnt    <= 24'h000000;
                    end else if (jog_timing) begin
                        if (!jog) begin
                            jog_timing <= 1'b0;
                            if (jog_step_count != 32'h00000000) begin
                                mode    <= M_JSTEP;
                                counted <= 1'b1;
                                rem     <= jog_step_count;
                                state   <= ST_HALF;
                                spg_launch(HALF_NUM, fs_m);
                            end
                        end else if (jog_cnt == JOG_LONG_CYC - 24'd1) begin
                            jog_timing <= 1'b0;
                            mode       <= M_JMAN;
                            counted    <= 1'b0;
                            state      <= ST_HALF;
                            spg_launch(HALF_NUM, fs_m);
                        end else begin
                            jog_cnt <= jog_cnt + 24'd1;
                        end
                    end else if (en && strt && !start_d && !brk &&
                                 total_step_count != 32'h00000000) begin
                        mode    <= M_NORMAL;
                        counted <= 1'b1;
                        rem     <= total_step_count;
                        state   <= ST_ACC;
                        spg_launch({8'h00, diff_m}, accel_step_increment);
                    end
                end
                ST_ACC: begin
                    if (!dv_busy) begin
                        accel_n <= dv_sat;
                        state   <= ST_BRK;
                        spg_launch({8'h00, diff_m}, brake_step_decrement);
                    end
                end
                ST_BRK: begin
                    if (!dv_busy) begin
                        brake_n <= dv_sat;
                        state   <= ST_HALF;
                        spg_launch(HALF_NUM, fs_m);
                    end
                end
                ST_HALF: begin
                    if (!dv_busy) begin
                        state <= ST_RUN;
                        spg_step_start(fs_m);
                    end
                end
                ST_RUN: begin
                    if (need_calc) begin
                        need_calc <= 1'b0;
                        next_mhz  <= nf;
                        spg_launch(HALF_NUM, nf);
                        last_step <= (counted && rem == 32'h00000000) ||
                                     ((brk_mode || (mode == M_JMAN && !jog))
                                      && current_frequency <= fs_m);
                    end
                    if (half_cnt > 32'h00000001) begin
                        half_cnt <= half_cnt - 32'h00000001;
                    end else if (out_q) begin
                        out_q    <= 1'b0;
                        half_cnt <= half_len;
                    end else if (last_step && !need_calc) begin
                        state     <= ST_IDLE;
                        brk_mode  <= 1'b0;
                        last_step <= 1'b0;
                    end else if (!dv_busy && !need_calc) begin
                        spg_step_start(next_mhz);
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // brake is honoured in normal jobs only; start edges while
            // a job runs fall through the idle-only start branch
            if (state != ST_IDLE && mode == M_NORMAL && brk && !brk_d)
                brk_mode <= 1'b1;
            if (state != ST_IDLE && mode == M_JMAN && !jog)
                brk_mode <= 1'b1;
            // abrupt stop: the motor may lose its reference point
            if (en_d && !en) begin
                state      <= ST_IDLE;
                out_q      <= 1'b0;
                brk_mode   <= 1'b0;
                need_calc  <= 1'b0;
                last_step  <= 1'b0;
                jog_timing <= 1'b0;
                dv_busy    <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

/* File: verilog/spg_defs.vh */
/*
 * Constants of the stepper pulse train generator: register indices,
 * control bit positions, reset values, field widths and timing figures.
 * Assumes a 20 MHz system clock; included by bare name.
 */
`ifndef SPG_DEFS_VH
`define SPG_DEFS_VH

// register indices; byte address is four times the index
`define SPG_IDX_CTRL        4'h0
`define SPG_IDX_TOTAL       4'h1
`define SPG_IDX_FSTART      4'h2
`define SPG_IDX_FOPER       4'h3
`define SPG_IDX_ACCEL_INC   4'h4
`define SPG_IDX_BRAKE_DEC   4'h5
`define SPG_IDX_JOG_STEPS   4'h6
`define SPG_IDX_JOG_FREQ    4'h7
`define SPG_IDX_STATUS      4'h8
`define SPG_IDX_CUR_FREQ    4'h9
`define SPG_IDX_ACCEL_N     4'ha
`define SPG_IDX_BRAKE_N     4'hb
`define SPG_IDX_LAST        4'hb
`define SPG_IDX_NONE        4'hf

// control register bits
`define SPG_CTRL_ENABLE     0
`define SPG_CTRL_START      1
`define SPG_CTRL_BRAKE      2
`define SPG_CTRL_JOG        3
`define SPG_CTRL_PIN        4
`define SPG_CTRL_W          5

// reset values
`define SPG_CTRL_RST        5'h00
`define SPG_CFG_RST         32'h00000000
`define SPG_FREQ_RST        20'h00000

// frequency settings are whole hertz in the low bits
`define SPG_FREQ_W          20
`define SPG_MHZ_PER_HZ      1000

// timing
`define SPG_CLK_HZ          40'd20000000
`define SPG_JOG_LONG_MS     500
`define SPG_MS_PER_S        1000
// jog hold that selects manual mode: 0.5 s of 20 MHz clocks
`define SPG_JOG_LONG_CYC    24'h989680

`endif

/* File: test/spg_monitor.sv */
/*
 * Port checker for spg_top: bus answers, pulse shape, start and stop.
 * Assumes one clock and the block's own register map.
 */
`timescale 1ns/1ps
`default_nettype none
module spg_monitor (
    input wire logic        clk_sys_i,
    input wire logic        arst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        fast_output_one_o,
    input wire logic        job_active_o
);
    logic [15:0] hi_cnt;
    logic [15:0] lo_cnt;
    logic [15:0] last_hi;
    logic        en_lvl;
    logic        wr_ctrl;
    assign wr_ctrl = psel_i && penable_i && pready_o && pwrite_i
                     && paddr_i == 8'h00;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    // lengths of the last high and low phases of the step line
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_cnt  <= 16'h0000;
            lo_cnt  <= 16'h0000;
            last_hi <= 16'h0000;
            en_lvl  <= 1'b0;
        end else begin
            if (fast_output_one_o) begin
                hi_cnt <= hi_cnt + 16'h0001;
                lo_cnt <= 16'h0000;
            end else begin
                hi_cnt <= 16'h0000;
                if (lo_cnt != 16'hffff) begin
                    lo_cnt <= lo_cnt + 16'h0001;
                end
            end
            if (!fast_output_one_o && hi_cnt != 16'h0000) begin
                last_hi <= hi_cnt;
            end
            if (wr_ctrl) begin
                en_lvl <= pwdata_i[0];
            end
        end
    end
    sequence s_disable;
        wr_ctrl && !pwdata_i[0];
    endsequence
    sequence s_halted;
        !job_active_o;
    endsequence
    chk_ready_access: assert property (psel_i && !penable_i |=> pready_o)
        else $error("pready missing in access cycle");
    chk_ready_single: assert property (pready_o |->
        (psel_i && penable_i) ##1 !pready_o)
        else $error("pready not a single access pulse");
    chk_err_unmapped: assert property (psel_i && !penable_i
        && paddr_i > 8'h2c |=> pslverr_o && pready_o)
        else $error("unmapped address not refused");
    chk_err_zero: assert property (pslverr_o && !pwrite_i |->
        prdata_o == 32'h00000000)
        else $error("refused read returned data");
    chk_square_half: assert property (
        $rose(fast_output_one_o) && job_active_o |-> lo_cnt >= last_hi)
        else $error("step low phase shorter than high phase");
    chk_start_enabled: assert property (
        $rose(job_active_o) |-> en_lvl)
        else $error("job began while disabled");
    chk_disable_stops: assert property (
        s_disable |-> ##[1:4] s_halted)
        else $error("disable did not stop the job");
    chk_brake_holds: assert property (
        wr_ctrl && pwdata_i[2] && job_active_o |=> job_active_o [*3])
        else $error("active dropped at brake request");
endmodule
bind spg_top spg_monitor spg_monitor_inst (.clk_sys_i, .arst_n_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .fast_output_one_o, .job_active_o);
`default_nettype wire

/* File: test/spg_power_stage.sv */
/*
 * Power stage input model: records the high phase length of each step
 * pulse and the low phase of all but the last. Assumes the step line is sampled on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module spg_power_stage (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic step_i
);
    int   hi_q[$];
    int   lo_q[$];
    int   run;
    logic prev;
    // input only: the step line has no other driver here
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev <= 1'b0;
            run  <= 0;
        end else begin
            prev <= step_i;
            run  <= (step_i != prev) ? 1 : run + 1;
            if (step_i && !prev && hi_q.size() > lo_q.size()) begin
                lo_q.push_back(run);
            end
            if (!step_i && prev) begin
                hi_q.push_back(run);
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
/*
 * Self-checking bench for spg_top: registers, normal job, brake, jog
 * modes and disable. Assumes zero wait state bus and 20 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int F_START = 32'h00004e20;
    localparam int F_OPER  = 32'h0000c350;
    localparam int F_JOG   = 32'h00009c40;
    localparam int ACC     = 32'h004c4b40;
    localparam int DEC     = 32'h00989680;
    logic        clk_sys_i;
    logic        arst_n_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd_q;
    logic        pready;
    logic        pslverr;
    logic        step;
    logic        active;
    logic        err_q;
    int          errors;
    int          samples_checked;
    int          seed;
    int          total;
    int          hq[$];
    int          lq[$];

    spg_top #(.JOG_LONG_CYC(24'h0000c8)) spg_top_inst (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .fast_output_one_o(step),
        .job_active_o(active));
    spg_power_stage spg_power_stage_inst (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .step_i(step));

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        @(posedge clk_sys_i);
        while (pready !== 1'b1) @(posedge clk_sys_i);
        rd_q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic clr();
        spg_power_stage_inst.hi_q.delete();
        spg_power_stage_inst.lo_q.delete();
    endtask

    // wait for the engine to go idle, then take the measured pulses
    task automatic finish_job();
        while (active !== 1'b0) @(posedge clk_sys_i);
        hq = spg_power_stage_inst.hi_q;
        lq = spg_power_stage_inst.lo_q;
    endtask

    task automatic go(input int tot);
        apb(1'b1, 8'h04, tot);
        clr();
        apb(1'b1, 8'h00, 32'h01);
        apb(1'b1, 8'h00, 32'h03);
        repeat (5) @(posedge clk_sys_i);
        check("job_active", active, 32'h1);
    endtask

    function automatic int half(input int f);
        return 32'h00989680 / f;
    endfunction

    function automatic int ramp(input int d);
        return (F_OPER - F_START) * 32'h3e8 / d;
    endfunction

    function automatic int hmin();
        int m;
        m = 32'h7fffffff;
        foreach (hq[i]) if (hq[i] < m) m = hq[i];
        return m;
    endfunction

    // half periods may only shrink, then only grow
    function automatic logic shape_ok();
        logic up;
        up = 1'b0;
        shape_ok = 1'b1;
        for (int i = 1; i < hq.size(); i++) begin
            if (hq[i] < hq[i-1] && up) shape_ok = 1'b0;
            if (hq[i] > hq[i-1]) up = 1'b1;
        end
    endfunction

    initial begin
        repeat (100000) @(posedge clk_sys_i);
        errors++;
        stop_test();
    end

    initial begin
        seed = 32'h3033;
        errors = 0;
        samples_checked = 0;
        arst_n_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl_reset", rd_q, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped_err", err_q, 32'h1);
        check("unmapped_data", rd_q, 32'h0);
        apb(1'b1, 8'h02, 32'h5);
        check("misaligned_err", err_q, 32'h1);
        apb(1'b1, 8'h00, 32'h02);
        repeat (20) @(posedge clk_sys_i);
        check("no_enable", active, 32'h0);
        apb(1'b1, 8'h08, F_START);
        apb(1'b1, 8'h0c, F_OPER);
        apb(1'b1, 8'h10, ACC);
        apb(1'b1, 8'h14, DEC);
        apb(1'b1, 8'h00, 32'h0);
        total = 12 + ($random(seed) & 7);
        go(total);
        // step counts are ready only once both divisions have run
        repeat (300) @(posedge clk_sys_i);
        apb(1'b0, 8'h28, 32'h0);
        check("accel_steps", rd_q, ramp(ACC));
        apb(1'b0, 8'h2c, 32'h0);
        check("brake_steps", rd_q, ramp(DEC));
        apb(1'b1, 8'h00, 32'h11);
        apb(1'b1, 8'h00, 32'h13);
        repeat (900) @(posedge clk_sys_i);
        apb(1'b1, 8'h00, 32'h01);
        finish_job();
        check("steps", hq.size(), total);
        check("first_half", hq[0], half(F_START));
        check("run_half", hmin(), half(F_OPER));
        check("last_half", hq[total-1], half(F_START));
        check("shape", shape_ok(), 32'h1);
        foreach (lq[i]) check("low_half", lq[i], hq[i]);
        go(60);
        repeat (5000) @(posedge clk_sys_i);
        apb(1'b1, 8'h00, 32'h05);
        repeat (3) @(posedge clk_sys_i);
        check("brake_active", active, 32'h1);
        finish_job();
        check("brake_short", hq.size() < 60, 32'h1);
        check("brake_end", hq[hq.size()-1], half(F_START));
        total = 1 + ($random(seed) & 7);
        apb(1'b1, 8'h18, total);
        apb(1'b1, 8'h1c, F_JOG);
        clr();
        apb(1'b1, 8'h00, 32'h09);
        repeat (50) @(posedge clk_sys_i);
        apb(1'b1, 8'h00, 32'h01);
        repeat (10) @(posedge clk_sys_i);
        check("jog_active", active, 32'h1);
        finish_job();
        check("jog_steps", hq.size(), total);
        check("jog_half", hmin(), half(F_START));
        clr();
        apb(1'b1, 8'h00, 32'h09);
        repeat (6000) @(posedge clk_sys_i);
        apb(1'b1, 8'h00, 32'h01);
        finish_job();
        check("jog_peak", hmin(), half(F_JOG));
        check("jog_shape", shape_ok(), 32'h1);
        go(60);
        repeat (3000) @(posedge clk_sys_i);
        apb(1'b1, 8'h00, 32'h00);
        repeat (4) @(posedge clk_sys_i);
        check("stop_now", active, 32'h0);
        check("stop_short", spg_power_stage_inst.hi_q.size() < 60,
              32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
